//--- src/agc_regs_pkg.sv
package agc_regs_pkg;

  // ==========================================================
  // Register numbers (page 0)
  localparam logic [7:0] ADDR_LEFT_GAIN   = 8'h20;
  localparam logic [7:0] ADDR_RIGHT_GAIN  = 8'h21;
  localparam logic [7:0] ADDR_LEFT_DEB    = 8'h22;
  localparam logic [7:0] ADDR_RIGHT_DEB   = 8'h23;
  localparam logic [7:0] ADDR_FLAGS       = 8'h24;

  // ==========================================================
  // Reset values and field positions
  localparam logic [7:0] GAIN_RST         = 8'h00;
  localparam logic [7:0] DEB_RST          = 8'h00;
  localparam logic [7:0] FLAGS_RST        = 8'h00;
  localparam int         NOISE_DEB_LSB    = 3;
  localparam int         SIG_DEB_MSB      = 2;
  localparam int         FLAG_LEFT_LSB    = 4;
  localparam logic [6:0] MAX_GAIN_CEIL    = 7'h77;
  localparam logic [4:0] NOISE_THR_OFF    = 5'h00;
  localparam logic [4:0] DEB_LAST_TABLE   = 5'h07;

  // ==========================================================
  // Debounce timing, counted in audio sample periods
  localparam int         FS_HZ            = 48000;
  localparam int         HALF_MS_PER_S    = 2000;
  localparam int         TICKS_PER_HALF   = FS_HZ / HALF_MS_PER_S;
  localparam int         LONG_STEP_HALF   = 128;
  localparam int         CNT_W            = 17;

  // ==========================================================
  // Per-channel status from the record path
  typedef struct packed {
    logic [7:0] agc_gain;
    logic [6:0] agc_max_gain;
    logic [4:0] noise_thr;
    logic       below_thr;
    logic [6:0] pga_applied;
    logic [6:0] pga_programmed;
    logic       adc_powered;
  } chan_in_t;

  typedef struct packed {
    logic pga_settled;
    logic adc_powered;
    logic below_noise;
    logic agc_saturated;
  } chan_flags_t;

endpackage

//--- src/agc_status_debounce_regs.sv
`timescale 1ns/1ps
`default_nettype none

module agc_status_debounce_regs
  import agc_regs_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_clk_en,
  input  wire logic              i_fs_tick,
  input  wire logic              i_double_rate_audio_mode,
  input  wire chan_in_t [1:0]    i_chan,
  input  wire logic [7:0]        i_reg_addr,
  input  wire logic              i_reg_wr,
  input  wire logic [7:0]        i_reg_wdata,
  input  wire logic              i_reg_rd,
  output logic [7:0]             o_reg_rdata,
  output logic                   o_reg_rvalid
);

  // ==========================================================
  // Debounce length in half-millisecond units
  function automatic logic [11:0] deb_half_ms(input logic [4:0] code);
    logic [11:0] len;
    len = 12'h000;
    if (code == 5'h00) begin
      len = 12'h000;
    end else if (code <= DEB_LAST_TABLE) begin
      len = 12'(12'h001 << (code - 5'h01));
    end else begin
      len = 12'(LONG_STEP_HALF * (code - DEB_LAST_TABLE));
    end
    return len;
  endfunction

  // ==========================================================
  // Address decode
  wire wr_left_deb  = i_clk_en && i_reg_wr && (i_reg_addr == ADDR_LEFT_DEB);
  wire wr_right_deb = i_clk_en && i_reg_wr && (i_reg_addr == ADDR_RIGHT_DEB);

  logic [7:0]      gain_ff [2];
  logic [7:0]      deb_ff  [2];
  logic            below_ff[2];
  logic [CNT_W-1:0] cnt_ff [2];
  logic [7:0]      flags_ff;
  chan_flags_t     chf     [2];

  // ==========================================================
  // Debounce register writes
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      deb_ff[0] <= DEB_RST;
      deb_ff[1] <= DEB_RST;
    end else begin
      if (wr_left_deb) begin
        deb_ff[0] <= i_reg_wdata;
      end
      if (wr_right_deb) begin
        deb_ff[1] <= i_reg_wdata;
      end
    end
  end

  // ==========================================================
  // Per-channel gain capture, detection debounce and flags
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    wire              det_on   = (i_chan[ch].noise_thr != NOISE_THR_OFF);
    wire              want     = det_on && i_chan[ch].below_thr;
    wire [4:0]        code_sel = below_ff[ch] ? {2'b00, deb_ff[ch][SIG_DEB_MSB:0]}
                                              : deb_ff[ch][7:NOISE_DEB_LSB];
    // Debounce counts sample ticks; ticks come twice as fast in
    // double-rate mode, so durations then deviate from nominal.
    wire [CNT_W-1:0]  len      = CNT_W'(deb_half_ms(code_sel) * TICKS_PER_HALF);
    wire              done     = (cnt_ff[ch] >= len);
    wire [6:0]        max_eff  = (i_chan[ch].agc_max_gain > MAX_GAIN_CEIL)
                                 ? MAX_GAIN_CEIL : i_chan[ch].agc_max_gain;
    wire              nxt_below;
    wire [CNT_W-1:0]  nxt_cnt;

    assign nxt_below = !det_on ? 1'b0 :
                       (want != below_ff[ch] && done) ? want : below_ff[ch];
    assign nxt_cnt   = (want == below_ff[ch] || !det_on || done) ? '0 :
                       (i_fs_tick ? cnt_ff[ch] + CNT_W'(1) : cnt_ff[ch]);

    assign chf[ch].pga_settled   = (i_chan[ch].pga_applied ==
                                    i_chan[ch].pga_programmed);
    assign chf[ch].adc_powered   = i_chan[ch].adc_powered;
    assign chf[ch].below_noise   = below_ff[ch];
    assign chf[ch].agc_saturated = (i_chan[ch].agc_gain == {1'b0, max_eff});

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        gain_ff[ch]  <= GAIN_RST;
        below_ff[ch] <= 1'b0;
        cnt_ff[ch]   <= '0;
      end else if (i_clk_en) begin
        gain_ff[ch]  <= i_chan[ch].agc_gain;
        below_ff[ch] <= nxt_below;
        cnt_ff[ch]   <= nxt_cnt;
      end
    end
  end

  // ==========================================================
  // Flags register and read port
  wire [7:0] nxt_flags = {chf[0], chf[1]};

  wire [7:0] nxt_rdata = (i_reg_addr == ADDR_LEFT_GAIN)  ? gain_ff[0] :
                         (i_reg_addr == ADDR_RIGHT_GAIN) ? gain_ff[1] :
                         (i_reg_addr == ADDR_LEFT_DEB)   ? deb_ff[0]  :
                         (i_reg_addr == ADDR_RIGHT_DEB)  ? deb_ff[1]  :
                         (i_reg_addr == ADDR_FLAGS)      ? flags_ff   : 8'h00;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_ff     <= FLAGS_RST;
      o_reg_rdata  <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else if (i_clk_en) begin
      flags_ff     <= nxt_flags;
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= nxt_rdata;
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_rd(logic [7:0] a);
    i_clk_en && i_reg_rd && i_reg_addr == a;
  endsequence

  property p_left_gain_rd;
    s_rd(ADDR_LEFT_GAIN) |=> o_reg_rvalid && o_reg_rdata == $past(gain_ff[0]);
  endproperty
  a_left_gain_rd: assert property (p_left_gain_rd) else $error("left gain readback wrong");

  property p_gain_ro;
    i_clk_en && i_reg_wr && i_reg_addr == ADDR_RIGHT_GAIN
      |=> gain_ff[1] == $past(i_chan[1].agc_gain);
  endproperty
  a_gain_ro: assert property (p_gain_ro) else $error("gain register took a write");

  property p_deb_wr;
    i_clk_en && i_reg_wr && i_reg_addr == ADDR_LEFT_DEB ##1 s_rd(ADDR_LEFT_DEB)
      |=> o_reg_rdata == $past(i_reg_wdata, 2);
  endproperty
  a_deb_wr: assert property (p_deb_wr) else $error("debounce write not read back");

  property p_flags_rd;
    s_rd(ADDR_FLAGS) |=> o_reg_rdata == $past(flags_ff);
  endproperty
  a_flags_rd: assert property (p_flags_rd) else $error("flags readback wrong");

  property p_pga;
    i_clk_en |=> flags_ff[7] == $past(i_chan[0].pga_applied == i_chan[0].pga_programmed);
  endproperty
  a_pga: assert property (p_pga) else $error("left PGA flag wrong");

  property p_pwr;
    i_clk_en |=> flags_ff[2] == $past(i_chan[1].adc_powered);
  endproperty
  a_pwr: assert property (p_pwr) else $error("right power flag wrong");

  property p_sat;
    i_clk_en && i_chan[0].agc_max_gain >= MAX_GAIN_CEIL
      |=> flags_ff[FLAG_LEFT_LSB] == ($past(i_chan[0].agc_gain) == {1'b0, MAX_GAIN_CEIL});
  endproperty
  a_sat: assert property (p_sat) else $error("saturation flag wrong");

  property p_det_off;
    i_clk_en && i_chan[1].noise_thr == NOISE_THR_OFF |=> !below_ff[1] ##1 !flags_ff[1];
  endproperty
  a_det_off: assert property (p_det_off) else $error("detection not disabled");

  property p_zero_deb;
    i_clk_en && deb_ff[0] == 8'h00 && i_chan[0].noise_thr != NOISE_THR_OFF
      |=> below_ff[0] == $past(i_chan[0].below_thr);
  endproperty
  a_zero_deb: assert property (p_zero_deb) else $error("zero debounce not immediate");

  property p_hold;
    i_clk_en && $changed(below_ff[0]) ##0 below_ff[0]
      |-> $past(g_chan[0].done);
  endproperty
  a_hold: assert property (p_hold) else $error("status changed before debounce");

  // ==========================================================
  // Register port checks
  property p_gain_cap;
    i_clk_en |=> gain_ff[0] == $past(i_chan[0].agc_gain);
  endproperty
  a_gain_cap: assert property (p_gain_cap) else $error("gain capture wrong");

  property p_right_gain_rd;
    s_rd(ADDR_RIGHT_GAIN) |=> o_reg_rvalid && o_reg_rdata == $past(gain_ff[1]);
  endproperty
  a_right_gain_rd: assert property (p_right_gain_rd) else $error("right gain read wrong");

  property p_deb_wr_r;
    i_clk_en && i_reg_wr && i_reg_addr == ADDR_RIGHT_DEB ##1 s_rd(ADDR_RIGHT_DEB)
      |=> o_reg_rdata == $past(i_reg_wdata, 2);
  endproperty
  a_deb_wr_r: assert property (p_deb_wr_r) else $error("right debounce write lost");

  property p_unmapped_rd;
    i_clk_en && i_reg_rd && (i_reg_addr < ADDR_LEFT_GAIN || i_reg_addr > ADDR_FLAGS)
      |=> o_reg_rdata == 8'h00;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");

  property p_rvalid_pulse;
    i_clk_en && !i_reg_rd |=> !o_reg_rvalid;
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("rvalid without read");

  property p_freeze;
    !i_clk_en |=> $stable(deb_ff[0]) && $stable(flags_ff) && $stable(o_reg_rdata);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");

  property p_left_pwr;
    i_clk_en |=> flags_ff[6] == $past(i_chan[0].adc_powered);
  endproperty
  a_left_pwr: assert property (p_left_pwr) else $error("left power flag wrong");

  property p_right_pga;
    i_clk_en |=> flags_ff[3] == $past(i_chan[1].pga_applied == i_chan[1].pga_programmed);
  endproperty
  a_right_pga: assert property (p_right_pga) else $error("right PGA flag wrong");

  property p_left_below;
    i_clk_en |=> flags_ff[5] == $past(below_ff[0]);
  endproperty
  a_left_below: assert property (p_left_below) else $error("left below flag wrong");

  property p_right_below;
    i_clk_en |=> flags_ff[1] == $past(below_ff[1]);
  endproperty
  a_right_below: assert property (p_right_below) else $error("right below flag wrong");

  property p_sat_neg;
    i_clk_en && i_chan[0].agc_gain[7] |=> !flags_ff[4];
  endproperty
  a_sat_neg: assert property (p_sat_neg) else $error("negative gain saturated");

  property p_sat_low;
    i_clk_en && i_chan[1].agc_max_gain < MAX_GAIN_CEIL
      |=> flags_ff[0] == ($past(i_chan[1].agc_gain) == {1'b0, $past(i_chan[1].agc_max_gain)});
  endproperty
  a_sat_low: assert property (p_sat_low) else $error("right saturation wrong");

  // ==========================================================
  // Debounce checks
  property p_noise_len1;
    !below_ff[0] && deb_ff[0][7:NOISE_DEB_LSB] == 5'h01 |-> g_chan[0].len == CNT_W'(TICKS_PER_HALF);
  endproperty
  a_noise_len1: assert property (p_noise_len1) else $error("noise code 1 length wrong");

  property p_noise_len8;
    !below_ff[0] && deb_ff[0][7:NOISE_DEB_LSB] == 5'h08
      |-> g_chan[0].len == CNT_W'(LONG_STEP_HALF * TICKS_PER_HALF);
  endproperty
  a_noise_len8: assert property (p_noise_len8) else $error("noise code 8 length wrong");

  property p_sig_len2;
    below_ff[0] && deb_ff[0][SIG_DEB_MSB:0] == 3'h2
      |-> g_chan[0].len == CNT_W'(2 * TICKS_PER_HALF);
  endproperty
  a_sig_len2: assert property (p_sig_len2) else $error("signal code 2 length wrong");

  property p_dra_cnt;
    i_clk_en && i_double_rate_audio_mode && i_fs_tick && g_chan[0].det_on &&
      g_chan[0].want != below_ff[0] && !g_chan[0].done
      |=> cnt_ff[0] == $past(cnt_ff[0]) + CNT_W'(1);
  endproperty
  a_dra_cnt: assert property (p_dra_cnt) else $error("tick count wrong in double rate");

  property p_cnt_clear;
    i_clk_en && !g_chan[1].det_on |=> cnt_ff[1] == '0;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("counter kept while off");

  property p_hold_fall;
    $changed(below_ff[0]) && !below_ff[0] && $past(g_chan[0].det_on)
      |-> $past(g_chan[0].done);
  endproperty
  a_hold_fall: assert property (p_hold_fall) else $error("status fell before debounce");

endmodule

`default_nettype wire

//--- test/agc_status_debounce_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

module agc_status_debounce_regs_tb
  import agc_regs_pkg::*;
;
  logic             i_sys_clk = 1'b0;
  logic             i_rst_n   = 1'b0;
  logic             i_clk_en  = 1'b1;
  logic             i_fs_tick = 1'b0;
  logic             i_double_rate_audio_mode = 1'b0;
  chan_in_t [1:0]   chan;
  logic [7:0]       reg_addr  = 8'h00;
  logic             reg_wr    = 1'b0;
  logic [7:0]       reg_wdata = 8'h00;
  logic             reg_rd    = 1'b0;
  logic [7:0]       o_reg_rdata;
  logic             o_reg_rvalid;
  int               failures        = 0;
  int               samples_checked = 0;
  int               cycle_count     = 0;

  always #12.5 i_sys_clk = ~i_sys_clk;

  agc_status_debounce_regs uut (
    .i_sys_clk                (i_sys_clk),
    .i_rst_n                  (i_rst_n),
    .i_clk_en                 (i_clk_en),
    .i_fs_tick                (i_fs_tick),
    .i_double_rate_audio_mode (i_double_rate_audio_mode),
    .i_chan                   (chan),
    .i_reg_addr               (reg_addr),
    .i_reg_wr                 (reg_wr),
    .i_reg_wdata              (reg_wdata),
    .i_reg_rd                 (reg_rd),
    .o_reg_rdata              (o_reg_rdata),
    .o_reg_rvalid             (o_reg_rvalid)
  );

  // ==========================================================
  // Register access and checking
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge i_sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= addr;
    reg_wdata <= data;
    @(posedge i_sys_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    @(posedge i_sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= addr;
    @(posedge i_sys_clk);
    reg_rd   <= 1'b0;
    #1;
    samples_checked++;
    if (o_reg_rvalid !== 1'b1 || o_reg_rdata !== exp) begin
      failures++;
      $display("mismatch t=%0t addr %h got %h exp %h", $time, addr, o_reg_rdata, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  always @(posedge i_sys_clk) begin
    cycle_count++;
    if (cycle_count == 10000) begin
      failures++;
      $display("mismatch t=%0t timeout", $time);
      report_and_stop();
    end
  end

  // ==========================================================
  // Test sequence
  initial begin
    chan = '0;
    chan[0].pga_programmed = 7'h01;
    chan[1].pga_programmed = 7'h01;
    chan[0].agc_max_gain   = 7'h7f;
    chan[1].agc_max_gain   = 7'h7f;
    wait_cyc(12);
    i_rst_n <= 1'b1;
    rd(ADDR_LEFT_GAIN, 8'h00);
    rd(ADDR_RIGHT_GAIN, 8'h00);
    rd(ADDR_LEFT_DEB, 8'h00);
    rd(ADDR_RIGHT_DEB, 8'h00);
    rd(ADDR_FLAGS, 8'h00);
    chan[0].agc_gain       <= 8'he8;
    chan[1].agc_gain       <= 8'h77;
    chan[0].pga_applied    <= 7'h01;
    chan[0].adc_powered    <= 1'b1;
    rd(ADDR_LEFT_GAIN, 8'he8);
    rd(ADDR_RIGHT_GAIN, 8'h77);
    wr(ADDR_LEFT_DEB, 8'ha5);
    wr(ADDR_RIGHT_DEB, 8'h5a);
    rd(ADDR_LEFT_DEB, 8'ha5);
    rd(ADDR_RIGHT_DEB, 8'h5a);
    wr(ADDR_LEFT_GAIN, 8'h33);
    wr(ADDR_FLAGS, 8'h33);
    rd(ADDR_LEFT_GAIN, 8'he8);
    rd(8'h30, 8'h00);
    rd(ADDR_FLAGS, 8'hc1);
    i_clk_en <= 1'b0;
    wr(ADDR_LEFT_DEB, 8'h00);
    i_clk_en <= 1'b1;
    rd(ADDR_LEFT_DEB, 8'ha5);
    // Noise code 1 (24 ticks) going below, signal code 2 (48 ticks) leaving
    i_fs_tick <= 1'b1;
    wr(ADDR_LEFT_DEB, 8'h0a);
    chan[0].noise_thr <= 5'h01;
    chan[0].below_thr <= 1'b1;
    wait_cyc(8);
    rd(ADDR_FLAGS, 8'hc1);
    wait_cyc(40);
    rd(ADDR_FLAGS, 8'he1);
    chan[0].below_thr <= 1'b0;
    wait_cyc(25);
    rd(ADDR_FLAGS, 8'he1);
    wait_cyc(40);
    rd(ADDR_FLAGS, 8'hc1);
    // Noise code 8 is 64 ms, 3072 ticks
    wr(ADDR_LEFT_DEB, 8'h40);
    i_double_rate_audio_mode <= 1'b1;
    chan[0].below_thr <= 1'b1;
    wait_cyc(2900);
    rd(ADDR_FLAGS, 8'hc1);
    wait_cyc(300);
    rd(ADDR_FLAGS, 8'he1);
    chan[0].noise_thr <= NOISE_THR_OFF;
    wait_cyc(5);
    rd(ADDR_FLAGS, 8'hc1);
    report_and_stop();
  end

endmodule

`default_nettype wire
